// *** verilog/vsi_pkg.sv ***
// constants and helpers for the video status indication block
// Contract
// - chroma anc flag spans whole packet
// - flag length taken from packet word count
// - header bit error suppresses packet flag
// - four bit detected video standard code
// - unknown format split interlaced or progressive
// - chroma crc mismatch high, match low
// - luma crc mismatch high, match low
// - fifo load low for one eav/sav word
package vsi_pkg;
  localparam int WORD_W = 10; // one channel word
  localparam logic [9:0] WORD_ONES = 10'h3ff; // trs / adf all ones
  localparam logic [9:0] WORD_ZERO = 10'h000; // trs / adf all zeros
  localparam int F_BIT = 8; // field bit in trs xyz
  localparam int H_BIT = 6; // eav/sav bit in trs xyz
  localparam int DELAY = 6; // words of lookahead before output
  localparam logic [8:0] ANC_TAIL = 9'h006; // words after first adf minus data
  localparam int CRC_W = 18; // line crc width
  localparam logic [2:0] POS_LN0 = 3'h1; // word positions after eav xyz
  localparam logic [2:0] POS_LN1 = 3'h2;
  localparam logic [2:0] POS_CR0 = 3'h3;
  localparam logic [2:0] POS_CR1 = 3'h4;
  localparam logic [11:0] TRS_PRE = 12'h003; // eav prefix words in active count
  localparam logic [11:0] TOT_1650 = 12'h672; // total words per line
  localparam logic [11:0] TOT_1980 = 12'h7bc;
  localparam logic [11:0] TOT_2200 = 12'h898;
  localparam logic [11:0] TOT_2640 = 12'ha50;
  localparam logic [11:0] TOT_2750 = 12'habe;
  localparam logic [11:0] ACT_1280 = 12'h500; // active words per line
  localparam logic [11:0] ACT_1920 = 12'h780;
  localparam logic [3:0] STD_720P_A = 4'h0; // standard codes
  localparam logic [3:0] STD_720P_B = 4'h1;
  localparam logic [3:0] STD_1080I_A = 4'h2;
  localparam logic [3:0] STD_1080I_B = 4'h3;
  localparam logic [3:0] STD_1080P_A = 4'h4;
  localparam logic [3:0] STD_1080P_B = 4'h5;
  localparam logic [3:0] STD_1080P_C = 4'h6;
  localparam logic [3:0] STD_UNK_I = 4'he;
  localparam logic [3:0] STD_UNK_P = 4'hf;
  localparam logic [3:0] STD_RESET = STD_720P_A; // default after reset
  localparam logic [10:0] PROG_LINES = 11'h7ff; // lines without f toggle
  localparam logic [3:0] REG_STATUS = 4'h0; // sticky events, w1c
  localparam logic [3:0] REG_MASK = 4'h4; // interrupt mask
  localparam logic [3:0] REG_INFO = 4'h8; // live state, read only
  localparam int EV_CRC_C = 0; // event bit positions
  localparam int EV_CRC_Y = 1;
  localparam int EV_STD = 2;
  localparam int EV_ANC = 3;
  localparam int EV_N = 4;

  // map measured line geometry to a standard code
  function automatic logic [3:0] std_lookup(input logic [11:0] tot,
      input logic [11:0] act, input logic ilace);
    logic [3:0] c;
    c = ilace ? STD_UNK_I : STD_UNK_P;
    if (act == ACT_1280 && !ilace) begin
      if (tot == TOT_1650) c = STD_720P_A;
      else if (tot == TOT_1980) c = STD_720P_B;
    end else if (act == ACT_1920 && ilace) begin
      if (tot == TOT_2200) c = STD_1080I_A;
      else if (tot == TOT_2640) c = STD_1080I_B;
    end else if (act == ACT_1920) begin
      if (tot == TOT_2200) c = STD_1080P_A;
      else if (tot == TOT_2640) c = STD_1080P_B;
      else if (tot == TOT_2750) c = STD_1080P_C;
    end
    return c;
  endfunction
endpackage

// *** verilog/vsi_anc_detect.sv ***
// chroma lookahead delay and ancillary packet flag
`timescale 1ns/1ps
module vsi_anc_detect (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] word_in,
  output logic [9:0] word_out,
  output logic flag,
  output logic pkt_start
);
  logic [9:0] d [0:5]; // d[0] oldest
  logic [8:0] cnt; // words still to flag
  logic hdr_ok; // valid header in window

  // even parity in bit 8, bit 9 its inverse
  function automatic logic par_ok(input logic [9:0] w);
    return (w[8] == ^w[7:0]) && (w[9] == !w[8]);
  endfunction

  // any header bit in error leaves hdr_ok low
  always_comb begin
    hdr_ok = d[0] == vsi_pkg::WORD_ZERO && d[1] == vsi_pkg::WORD_ONES &&
      d[2] == vsi_pkg::WORD_ONES && par_ok(d[3]) && par_ok(d[4]) &&
      par_ok(d[5]);
  end

  // lookahead shift and aligned output word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) d[i] <= 10'h000;
      word_out <= 10'h000;
    end else begin
      for (int i = 0; i < 5; i++) d[i] <= d[i+1];
      d[5] <= word_in;
      word_out <= d[0];
    end
  end

  // flag first adf through checksum
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 9'h000;
      flag <= 1'b0;
      pkt_start <= 1'b0;
    end else if (cnt == 9'h000 && hdr_ok) begin
      cnt <= vsi_pkg::ANC_TAIL + {1'b0, d[5][7:0]};
      flag <= 1'b1;
      pkt_start <= 1'b1;
    end else begin
      flag <= cnt != 9'h000;
      cnt <= (cnt != 9'h000) ? cnt - 9'h001 : cnt;
      pkt_start <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence anc_hdr_s;
    cnt == 9'h000 && hdr_ok;
  endsequence
  anc_len_a: assert property (anc_hdr_s |=> flag && cnt ==
    vsi_pkg::ANC_TAIL + {1'b0, $past(d[5][7:0])}) else $error("anc length");
  anc_hold_a: assert property (cnt != 9'h000 |=> flag)
    else $error("anc flag dropped");
  anc_hdr_a: assert property (cnt == 9'h000 && !hdr_ok |=> !flag)
    else $error("anc flag on bad header");
endmodule // vsi_anc_detect

// *** verilog/vsi_line_crc.sv ***
// line crc of one channel and mismatch indication
`timescale 1ns/1ps
module vsi_line_crc (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] word,
  input wire logic start,
  input wire logic en,
  input wire logic cr0,
  input wire logic cr1,
  output logic mismatch,
  output logic err_ev
);
  logic [17:0] crc; // running line crc
  logic [8:0] emb_lo; // embedded crc low half

  // one word, lsb first, x^18 + x^5 + x^4 + 1
  function automatic logic [17:0] crc_step(input logic [17:0] c,
      input logic [9:0] w);
    logic fb;
    fb = 1'b0;
    for (int i = 0; i < 10; i++) begin
      fb = c[0] ^ w[i];
      c = {fb, c[17:1]};
      c[12] = c[12] ^ fb;
      c[13] = c[13] ^ fb;
    end
    return c;
  endfunction

  // accumulate from first active word through ln1
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) crc <= 18'h00000;
    else if (start) crc <= crc_step(18'h00000, word);
    else if (en) crc <= crc_step(crc, word);
  end

  // compare at second crc word, hold until next line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      emb_lo <= 9'h000;
      mismatch <= 1'b0;
      err_ev <= 1'b0;
    end else begin
      if (cr0) emb_lo <= word[8:0];
      if (cr1) mismatch <= {word[8:0], emb_lo} != crc;
      err_ev <= cr1 && ({word[8:0], emb_lo} != crc);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  crc_cmp_a: assert property (cr1 |=> mismatch ==
    ($past({word[8:0], emb_lo}) != $past(crc))) else $error("crc compare");
  crc_hold_a: assert property (!cr1 |=> $stable(mismatch))
    else $error("crc flag moved");
endmodule // vsi_line_crc

// *** verilog/vsi_top.sv ***
// output status indication: anc flag, standard, crc, fifo load
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module vsi_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] luma_in,
  input wire logic [9:0] chroma_in,
  input wire logic load_eav_sel,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [9:0] luma_out,
  output logic [9:0] chroma_out,
  output logic chroma_anc_flag,
  output logic [3:0] video_standard_code,
  output logic chroma_crc_mismatch,
  output logic luma_crc_mismatch,
  output logic fifo_load_n,
  output logic irq
);
  logic [9:0] ld [0:5]; // luma lookahead, ld[0] oldest
  logic xyz; // trs xyz word at input
  logic is_eav; // input word is eav xyz
  logic is_sav; // input word is sav xyz
  logic [5:0] eav_pipe; // eav marker tracking the delay
  logic [5:0] sav_pipe; // sav marker tracking the delay
  logic [2:0] pos; // word index after eav xyz
  logic in_line; // inside crc span of the line
  logic sav_d; // first active word follows
  logic [11:0] tot_cnt; // words since last eav
  logic [11:0] act_cnt; // words since last sav
  logic [11:0] prev_tot; // previous line length
  logic f_prev; // field bit of previous eav
  logic [10:0] lines_same; // lines since field toggle
  logic interlaced; // field bit seen toggling
  logic [3:0] next_code; // lookup of current line
  logic ev_std; // standard code changed
  logic ev_crc_c; // chroma crc mismatch event
  logic ev_crc_y; // luma crc mismatch event
  logic ev_anc; // chroma packet started
  logic [vsi_pkg::EV_N-1:0] status; // sticky events
  logic [vsi_pkg::EV_N-1:0] mask; // interrupt enables
  logic [vsi_pkg::EV_N-1:0] events; // this cycle's events
  logic [vsi_pkg::EV_N-1:0] w1c; // bits cleared by write

  // trs xyz recognised from input and lookahead history
  always_comb begin
    xyz = luma_in[9] && ld[5] == vsi_pkg::WORD_ZERO &&
      ld[4] == vsi_pkg::WORD_ZERO && ld[3] == vsi_pkg::WORD_ONES;
    is_eav = xyz && luma_in[vsi_pkg::H_BIT];
    is_sav = xyz && !luma_in[vsi_pkg::H_BIT];
  end

  // luma lookahead, same depth as chroma path
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) ld[i] <= 10'h000;
      luma_out <= 10'h000;
    end else begin
      for (int i = 0; i < 5; i++) ld[i] <= ld[i+1];
      ld[5] <= luma_in;
      luma_out <= ld[0];
    end
  end

  // chroma delay and packet flag
  vsi_anc_detect u_anc (
    .clk(clk),
    .nrst(nrst),
    .word_in(chroma_in),
    .word_out(chroma_out),
    .flag(chroma_anc_flag),
    .pkt_start(ev_anc)
  );

  // markers travel with their word to the output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eav_pipe <= 6'h00;
      sav_pipe <= 6'h00;
    end else begin
      eav_pipe <= {eav_pipe[4:0], is_eav};
      sav_pipe <= {sav_pipe[4:0], is_sav};
    end
  end

  // load strobe low for the selected trs word only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) fifo_load_n <= 1'b1;
    else if (load_eav_sel) fifo_load_n <= !eav_pipe[5];
    else fifo_load_n <= !sav_pipe[5];
  end

  // position of ln and crc words after eav
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pos <= 3'h0;
    else if (is_eav) pos <= vsi_pkg::POS_LN0;
    else if (pos == vsi_pkg::POS_CR1) pos <= 3'h0;
    else if (pos != 3'h0) pos <= pos + 3'h1;
  end

  // crc span: first active word through ln1
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_line <= 1'b0;
      sav_d <= 1'b0;
    end else begin
      sav_d <= is_sav;
      if (is_sav) in_line <= 1'b1;
      else if (pos == vsi_pkg::POS_LN1) in_line <= 1'b0;
    end
  end

  // chroma channel line crc
  vsi_line_crc u_crc_c (
    .clk(clk),
    .nrst(nrst),
    .word(chroma_in),
    .start(sav_d),
    .en(in_line),
    .cr0(pos == vsi_pkg::POS_CR0),
    .cr1(pos == vsi_pkg::POS_CR1),
    .mismatch(chroma_crc_mismatch),
    .err_ev(ev_crc_c)
  );

  // luma channel line crc
  vsi_line_crc u_crc_y (
    .clk(clk),
    .nrst(nrst),
    .word(luma_in),
    .start(sav_d),
    .en(in_line),
    .cr0(pos == vsi_pkg::POS_CR0),
    .cr1(pos == vsi_pkg::POS_CR1),
    .mismatch(luma_crc_mismatch),
    .err_ev(ev_crc_y)
  );

  // line and active word counters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tot_cnt <= 12'h001;
      act_cnt <= 12'h000;
    end else begin
      tot_cnt <= is_eav ? 12'h001 : tot_cnt + 12'h001;
      act_cnt <= is_sav ? 12'h000 : act_cnt + 12'h001;
    end
  end

  // field toggling tells interlaced from progressive
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      f_prev <= 1'b0;
      lines_same <= 11'h000;
      interlaced <= 1'b0;
    end else if (is_eav) begin
      f_prev <= luma_in[vsi_pkg::F_BIT];
      if (luma_in[vsi_pkg::F_BIT] != f_prev) begin
        interlaced <= 1'b1;
        lines_same <= 11'h000;
      end else if (lines_same == vsi_pkg::PROG_LINES) begin
        interlaced <= 1'b0;
      end else begin
        lines_same <= lines_same + 11'h001;
      end
    end
  end

  // geometry of the line that just ended
  always_comb begin
    next_code = vsi_pkg::std_lookup(tot_cnt, act_cnt - vsi_pkg::TRS_PRE,
      interlaced);
  end

  // code updates after two equal line lengths
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_tot <= 12'h000;
      video_standard_code <= vsi_pkg::STD_RESET;
      ev_std <= 1'b0;
    end else begin
      ev_std <= 1'b0;
      if (is_eav) begin
        prev_tot <= tot_cnt;
        if (tot_cnt == prev_tot && next_code != video_standard_code) begin
          video_standard_code <= next_code;
          ev_std <= 1'b1;
        end
      end
    end
  end

  // event gathering and write-one-to-clear
  always_comb begin
    events = '0;
    events[vsi_pkg::EV_CRC_C] = ev_crc_c;
    events[vsi_pkg::EV_CRC_Y] = ev_crc_y;
    events[vsi_pkg::EV_STD] = ev_std;
    events[vsi_pkg::EV_ANC] = ev_anc;
    w1c = (reg_wr && reg_addr == vsi_pkg::REG_STATUS) ?
      reg_wdata[vsi_pkg::EV_N-1:0] : '0;
  end

  // sticky status, a new event beats a clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) status <= '0;
    else status <= (status & ~w1c) | events;
  end

  // mask register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) mask <= '0;
    else if (reg_wr && reg_addr == vsi_pkg::REG_MASK)
      mask <= reg_wdata[vsi_pkg::EV_N-1:0];
  end

  // level interrupt from unmasked status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) irq <= 1'b0;
    else irq <= |(status & mask);
  end

  // read data in the cycle after the strobe only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        vsi_pkg::REG_STATUS: reg_rdata <= {28'h0000000, status};
        vsi_pkg::REG_MASK: reg_rdata <= {28'h0000000, mask};
        vsi_pkg::REG_INFO: reg_rdata <= {24'h000000, interlaced,
          luma_crc_mismatch, chroma_crc_mismatch, chroma_anc_flag,
          video_standard_code};
        default: reg_rdata <= 32'h00000000; // unmapped reads zero
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence eav_out_s;
    eav_pipe[5] && load_eav_sel;
  endsequence
  sequence sav_out_s;
    sav_pipe[5] && !load_eav_sel;
  endsequence

  fifo_eav_a: assert property (eav_out_s |=> !fifo_load_n)
    else $error("no load pulse on eav");
  fifo_sav_a: assert property (sav_out_s |=> !fifo_load_n)
    else $error("no load pulse on sav");
  fifo_single_a: assert property (!fifo_load_n |=> fifo_load_n)
    else $error("load pulse too long");
  fifo_idle_a: assert property (!eav_pipe[5] && !sav_pipe[5] |=>
    fifo_load_n) else $error("stray load pulse");
  fifo_align_a: assert property (is_eav ##0 load_eav_sel[*7] |=>
    !fifo_load_n) else $error("load pulse misaligned");
  std_unk_i_a: assert property ($changed(video_standard_code) &&
    video_standard_code == vsi_pkg::STD_UNK_I |-> $past(interlaced))
    else $error("unknown interlaced wrongly");
  std_unk_p_a: assert property ($changed(video_standard_code) &&
    video_standard_code == vsi_pkg::STD_UNK_P |-> !$past(interlaced))
    else $error("unknown progressive wrongly");
  std_update_a: assert property ($changed(video_standard_code) |->
    $past(is_eav) && $past(tot_cnt) == $past(prev_tot)) else $error("code moved");
  crc_pos_a: assert property (is_eav |=> pos == vsi_pkg::POS_LN0 ##3
    pos == vsi_pkg::POS_CR1) else $error("crc word position");
  sticky_set_a: assert property (ev_crc_c |=> status[vsi_pkg::EV_CRC_C])
    else $error("event lost");
  irq_level_a: assert property (|(status & mask) |=> irq)
    else $error("irq missing");
endmodule // vsi_top

// *** sim/vsi_sink_model.sv ***
// downstream sink model: measures anc flag runs and fifo load pulses
`timescale 1ns/1ps
module vsi_sink_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] luma_out,
  input wire logic [9:0] chroma_out,
  input wire logic chroma_anc_flag,
  input wire logic fifo_load_n,
  output logic [15:0] run_len,
  output logic [15:0] runs,
  output logic [9:0] run_word,
  output logic [15:0] loads,
  output logic [9:0] load_word
);
  logic [15:0] cur; // words of the packet in progress

  // flag runs: length, count and the word under the rising flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur <= 16'h0000;
      run_len <= 16'h0000;
      runs <= 16'h0000;
      run_word <= 10'h000;
    end else if (chroma_anc_flag) begin
      cur <= cur + 16'h0001;
      // first flagged word is kept
      if (cur == 16'h0000) run_word <= chroma_out;
    end else if (cur != 16'h0000) begin
      // run finished
      run_len <= cur;
      runs <= runs + 16'h0001;
      cur <= 16'h0000;
    end
  end

  // fifo load strobe: count and the luma word it marks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loads <= 16'h0000;
      load_word <= 10'h000;
    end else if (!fifo_load_n) begin
      loads <= loads + 16'h0001;
      load_word <= luma_out;
    end
  end
endmodule // vsi_sink_model

// *** sim/tb_vsi_top.sv ***
// self-checking bench for the video status indication block
`timescale 1ns/1ps
module tb_vsi_top;
  logic clk, nrst, load_eav_sel, reg_wr, reg_rd; // bench driven controls
  logic [9:0] luma_in, chroma_in, luma_out, chroma_out; // video words
  logic [3:0] reg_addr, video_standard_code; // register address, code
  logic [31:0] reg_wdata, reg_rdata, rd_val; // register data
  logic chroma_anc_flag, chroma_crc_mismatch, luma_crc_mismatch, fifo_load_n, irq;
  logic [15:0] run_len, runs, loads; // sink measurements
  logic [9:0] run_word, load_word; // sink captured words
  logic [9:0] ly [0:4095]; // luma words of one line
  logic [9:0] lc [0:4095]; // chroma words of one line
  logic fld, sel; // field bit, load select in force
  int fails, checks, seed, n; // counters, seed, line number
  int tots [4] = '{1980, 1700, 2200, 2000}; // line totals per group
  int acts [4] = '{1280, 1280, 1920, 1920}; // active words per group
  logic [3:0] codes [4] = '{vsi_pkg::STD_720P_B, vsi_pkg::STD_UNK_P,
    vsi_pkg::STD_1080I_A, vsi_pkg::STD_UNK_I}; // expected codes

  vsi_top dut (.clk(clk), .nrst(nrst), .luma_in(luma_in), .chroma_in(chroma_in),
    .load_eav_sel(load_eav_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .luma_out(luma_out),
    .chroma_out(chroma_out), .chroma_anc_flag(chroma_anc_flag),
    .video_standard_code(video_standard_code), .chroma_crc_mismatch(chroma_crc_mismatch),
    .luma_crc_mismatch(luma_crc_mismatch), .fifo_load_n(fifo_load_n), .irq(irq));

  vsi_sink_model sink (.clk(clk), .nrst(nrst), .luma_out(luma_out),
    .chroma_out(chroma_out), .chroma_anc_flag(chroma_anc_flag),
    .fifo_load_n(fifo_load_n), .run_len(run_len), .runs(runs), .run_word(run_word),
    .loads(loads), .load_word(load_word));

  // 250 mhz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // trs xyz word with v low
  function automatic logic [9:0] xyz(input logic f, input logic h);
    return {1'b1, f, 1'b0, h, h, f ^ h, f, f ^ h, 2'b00};
  endfunction

  // header word with even parity bit and its inverse
  function automatic logic [9:0] par(input logic [7:0] x);
    return {~(^x), ^x, x};
  endfunction

  // line crc, lsb first, x^18+x^5+x^4+1
  function automatic logic [17:0] crc_word(input logic [17:0] c, input logic [9:0] w);
    for (int i = 0; i < 10; i++) c = (c >> 1) ^ ((c[0] ^ w[i]) ? 18'h23000 : 18'h00000);
    return c;
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic final_report();
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // one line: sav, active, eav, line number, crc, blanking, one anc packet
  task automatic send_line(input int tot, input int act, input logic nsel);
    int pos, dc, e;
    logic [17:0] cy, cc;
    logic bad;
    logic [15:0] r0, l0;
    r0 = runs;
    l0 = loads;
    cy = 18'h00000;
    cc = 18'h00000;
    e = (n == 2) ? 3 : $random(seed) & 3;
    dc = (n == 1) ? 255 : (n == 3) ? 0 : {$random(seed)} % 40;
    pos = n[0] ? 20 : act + 12;
    bad = (n % 5 == 4);
    for (int i = 0; i < tot; i++) begin
      ly[i] = (i >= 4 && i < act + 4) ? 10'(32'h40 + {$random(seed)} % 896) : 10'h040;
      lc[i] = (i >= 4 && i < act + 4) ? 10'(32'h40 + {$random(seed)} % 896) : 10'h200;
    end
    // timing reference words on both channels
    for (int k = 0; k < 4; k++) begin
      ly[k] = k == 0 ? 10'h3ff : k == 3 ? xyz(fld, 1'b0) : 10'h000;
      ly[act + 4 + k] = k == 0 ? 10'h3ff : k == 3 ? xyz(fld, 1'b1) : 10'h000;
      lc[k] = ly[k];
      lc[act + 4 + k] = ly[act + 4 + k];
    end
    // anc packet; a bad header carries a parity error in its id word
    lc[pos] = 10'h000;
    lc[pos + 1] = 10'h3ff;
    lc[pos + 2] = 10'h3ff;
    lc[pos + 3] = par(8'h41) ^ {9'h000, bad};
    lc[pos + 4] = par(8'h05);
    lc[pos + 5] = par(8'(dc));
    for (int k = 0; k < dc; k++) lc[pos + 6 + k] = 10'(32'h40 + {$random(seed)} % 896);
    lc[pos + 6 + dc] = 10'h200;
    // line crc words, optionally corrupted
    for (int i = 4; i < act + 10; i++) begin
      cy = crc_word(cy, ly[i]);
      cc = crc_word(cc, lc[i]);
    end
    ly[act + 10] = {~cy[8], cy[8:0]} ^ {9'h000, e[1]};
    ly[act + 11] = {~cy[17], cy[17:9]};
    lc[act + 10] = {~cc[8], cc[8:0]} ^ {9'h000, e[0]};
    lc[act + 11] = {~cc[17], cc[17:9]};
    for (int i = 0; i < tot; i++) begin
      @(posedge clk);
      luma_in <= ly[i];
      chroma_in <= lc[i];
      // select for the next line changes in blanking
      if (i == tot - 20) load_eav_sel <= nsel;
    end
    #1;
    chk(chroma_crc_mismatch, e[0]);
    chk(luma_crc_mismatch, e[1]);
    chk(loads, l0 + 16'h0001);
    chk(load_word, xyz(fld, sel));
    chk(runs, r0 + 16'(!bad));
    if (!bad) begin
      chk(run_len, 32'(7 + dc));
      chk(run_word, 10'h000);
    end
    sel = nsel;
    n++;
  endtask

  // main sequence
  initial begin
    seed = 38496;
    fails = 0;
    checks = 0;
    n = 0;
    fld = 1'b0;
    sel = 1'b1;
    nrst = 1'b0;
    luma_in = 10'h040;
    chroma_in = 10'h200;
    load_eav_sel = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk(fifo_load_n, 1'b1);
    chk(video_standard_code, vsi_pkg::STD_RESET);
    @(posedge clk);
    nrst <= 1'b1;
    rd(vsi_pkg::REG_MASK);
    chk(rd_val, 32'h00000000);
    // four line groups: two progressive, two interlaced
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 4; k++) begin
        if (g >= 2) fld = ~fld;
        send_line(tots[g], acts[g], 1'($random(seed)));
      end
      chk(video_standard_code, codes[g]);
    end
    // interrupt: all four events seen, masked, unmasked, cleared
    rd(vsi_pkg::REG_STATUS);
    chk(rd_val, 32'h0000000f);
    chk(irq, 1'b0);
    wr(vsi_pkg::REG_MASK, 32'h0000000f);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    rd(vsi_pkg::REG_INFO);
    chk(rd_val[3:0], vsi_pkg::STD_UNK_I);
    chk({rd_val[7], rd_val[4]}, 2'b10);
    wr(vsi_pkg::REG_STATUS, 32'h0000000f);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    rd(vsi_pkg::REG_STATUS);
    chk(rd_val, 32'h00000000);
    rd(4'hc);
    chk(rd_val, 32'h00000000);
    final_report();
  end

  // watchdog against a hang
  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule // tb_vsi_top
